//--- rtl/gtfc_map.vh
// Register map, field positions, reset values and timing counts of the
// general timer and free-running counter block.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
`ifndef GTFC_MAP_VH
`define GTFC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GTFC_ADDR_W          12
`define GTFC_DATA_W          32
`define GTFC_OFF_CFG         12'h08c
`define GTFC_OFF_CNT         12'h090
`define GTFC_OFF_FREE        12'h09c
`define GTFC_OFF_IRQ_STAT    12'h0a0
`define GTFC_OFF_IRQ_MASK    12'h0a4

// ****************************************************************
// Field positions
// ****************************************************************
`define GTFC_CFG_EN_BIT      29
`define GTFC_LOAD_MSB        15
`define GTFC_LOAD_W          16
`define GTFC_WRAP_BIT        0

// ****************************************************************
// Reset values
// ****************************************************************
`define GTFC_LOAD_RST        16'hffff
`define GTFC_CNT_RST         16'hffff
`define GTFC_FREE_RST        32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define GTFC_CLK_MHZ         100
`define GTFC_TICK_US         100
`define GTFC_TICK_CYC        (`GTFC_TICK_US * `GTFC_CLK_MHZ)
`define GTFC_FREE_MHZ        25
`define GTFC_FREE_CYC        (`GTFC_CLK_MHZ / `GTFC_FREE_MHZ)
`define GTFC_FREE_CLR_NS     160
`define GTFC_FREE_CLR_CYC    ((`GTFC_FREE_CLR_NS * `GTFC_CLK_MHZ) / 1000)
`define GTFC_DIV_W           16

`endif

//--- rtl/gtfc_tick_div.v
// Clock-enable divider: one-cycle pulse every DIV cycles of sys_clk_i.
// Assumes the caller holds run_i low to stop it; it then restarts from zero.
`timescale 1ns/1ps
`default_nettype none

module gtfc_tick_div #(
    parameter integer DIV = 4,
    parameter integer W   = 16
) (
    input  wire         sys_clk_i,
    input  wire         rst_n_i,
    input  wire         run_i,
    output reg          tick_o
);

    localparam integer LAST_I = DIV - 1;
    localparam [W-1:0] LAST   = LAST_I[W-1:0];
    localparam [W-1:0] ONE    = {{(W-1){1'b0}}, 1'b1};

    reg [W-1:0] cnt;

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    // Cleared while stopped so that the first period after a start is whole
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt    <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt    <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt == LAST) begin
            cnt    <= {W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + ONE;
            tick_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- rtl/gtfc_timer_top.v
// General timer with preload, wrap interrupt and 32-bit free-running counter.
// Assumes a register master on sys_clk_i with one-cycle strobes, no wait.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gtfc_map.vh"

module gtfc_timer_top #(
    parameter integer TICK_CYCLES = `GTFC_TICK_CYC
) (
    input  wire                      sys_clk_i,
    input  wire                      rst_n_i,
    input  wire [`GTFC_ADDR_W-1:0]   addr_i,
    input  wire [`GTFC_DATA_W-1:0]   wr_data_i,
    input  wire                      wr_en_i,
    input  wire                      rd_en_i,
    output reg  [`GTFC_DATA_W-1:0]   rd_data_o,
    output reg                       irq_o
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam [`GTFC_LOAD_W-1:0] LOAD_RST  = `GTFC_LOAD_RST;
    localparam [`GTFC_LOAD_W-1:0] CNT_RST   = `GTFC_CNT_RST;
    localparam [`GTFC_LOAD_W-1:0] CNT_ZERO  = 16'h0000;
    localparam [`GTFC_LOAD_W-1:0] CNT_ONE   = 16'h0001;
    localparam [`GTFC_DATA_W-1:0] FREE_RST  = `GTFC_FREE_RST;
    localparam [`GTFC_DATA_W-1:0] FREE_ONE  = 32'h0000_0001;
    localparam [`GTFC_DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // Longest clear time after reset, in cycles; the counter clears on the
    // reset edge itself, well inside this bound
    localparam integer FREE_CLR_CYC = `GTFC_FREE_CLR_CYC;

    // ****************************************************************
    // State
    // ****************************************************************
    reg                       run_en;
    reg  [`GTFC_LOAD_W-1:0]   timer_preload_value;
    reg  [`GTFC_LOAD_W-1:0]   timer_current_count;
    reg  [`GTFC_DATA_W-1:0]   free_count_value;
    reg                       timer_wrap_flag;
    reg                       timer_wrap_irq_enable;

    // ****************************************************************
    // Combinational signals
    // ****************************************************************
    reg                       wr_cfg;
    reg                       wr_stat;
    reg                       wr_mask;
    reg  [`GTFC_DATA_W-1:0]   next_rd_data;
    reg  [`GTFC_LOAD_W-1:0]   next_preload;
    reg  [`GTFC_LOAD_W-1:0]   next_count;
    reg                       next_wrap_flag;
    wire                      wr_run_bit;
    wire [`GTFC_LOAD_W-1:0]   wr_load_field;
    wire                      run_falling;
    wire                      timer_tick;
    wire                      free_tick;
    wire                      wrap_evt;

    assign wr_run_bit    = wr_data_i[`GTFC_CFG_EN_BIT];
    assign wr_load_field = wr_data_i[`GTFC_LOAD_MSB:0];
    assign run_falling   = wr_cfg && run_en && !wr_run_bit;

    // ****************************************************************
    // Tick dividers
    // ****************************************************************
    // The 100 us prescaler is held clear while the timer is stopped
    gtfc_tick_div #(
        .DIV (TICK_CYCLES),
        .W   (`GTFC_DIV_W)
    ) u_timer_div (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (run_en),
        .tick_o    (timer_tick)
    );

    // The 25 MHz rate is an enable from the system clock, not a second clock
    gtfc_tick_div #(
        .DIV (`GTFC_FREE_CYC),
        .W   (`GTFC_DIV_W)
    ) u_free_div (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (1'b1),
        .tick_o    (free_tick)
    );

    // ****************************************************************
    // Write decode
    // ****************************************************************
    always @* begin
        wr_cfg  = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (wr_en_i && addr_i == `GTFC_OFF_CFG) begin
            wr_cfg = 1'b1;
        end else if (wr_en_i && addr_i == `GTFC_OFF_IRQ_STAT) begin
            wr_stat = 1'b1;
        end else if (wr_en_i && addr_i == `GTFC_OFF_IRQ_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    // A falling enable overrides the preload written in the same cycle
    always @* begin
        next_preload = timer_preload_value;
        if (run_falling) begin
            next_preload = LOAD_RST;
        end else if (wr_cfg) begin
            next_preload = wr_load_field;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            run_en              <= 1'b0;
            timer_preload_value <= LOAD_RST;
        end else begin
            if (wr_cfg) begin
                run_en <= wr_run_bit;
            end
            timer_preload_value <= next_preload;
        end
    end

    // ****************************************************************
    // General timer count
    // ****************************************************************
    // A config write in the same cycle as a tick wins; that tick is dropped
    assign wrap_evt = run_en && timer_tick && !wr_cfg &&
                      (timer_current_count == CNT_ZERO);

    always @* begin
        next_count = timer_current_count;
        if (wr_cfg) begin
            next_count = next_preload;
        end else if (wrap_evt) begin
            next_count = CNT_RST;
        end else if (run_en && timer_tick) begin
            next_count = timer_current_count - CNT_ONE;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            timer_current_count <= CNT_RST;
        end else begin
            timer_current_count <= next_count;
        end
    end

    // ****************************************************************
    // Free-running counter
    // ****************************************************************
    // Cleared on the reset edge, so it reads zero one cycle after reset
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            free_count_value <= FREE_RST;
        end else if (free_tick) begin
            free_count_value <= free_count_value + FREE_ONE;
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // A wrap in the cycle of a clear write keeps the flag set
    always @* begin
        next_wrap_flag = timer_wrap_flag;
        if (wrap_evt) begin
            next_wrap_flag = 1'b1;
        end else if (wr_stat && wr_data_i[`GTFC_WRAP_BIT]) begin
            next_wrap_flag = 1'b0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            timer_wrap_flag       <= 1'b0;
            timer_wrap_irq_enable <= 1'b0;
        end else begin
            timer_wrap_flag <= next_wrap_flag;
            if (wr_mask) begin
                timer_wrap_irq_enable <= wr_data_i[`GTFC_WRAP_BIT];
            end
        end
    end

    // Registered, so the line follows the flag by one cycle
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= timer_wrap_flag && timer_wrap_irq_enable;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped addresses and reserved bits read as zero
    always @* begin
        next_rd_data = DATA_ZERO;
        if (addr_i == `GTFC_OFF_CFG) begin
            next_rd_data[`GTFC_CFG_EN_BIT]  = run_en;
            next_rd_data[`GTFC_LOAD_MSB:0]  = timer_preload_value;
        end else if (addr_i == `GTFC_OFF_CNT) begin
            next_rd_data[`GTFC_LOAD_MSB:0]  = timer_current_count;
        end else if (addr_i == `GTFC_OFF_FREE) begin
            next_rd_data = free_count_value;
        end else if (addr_i == `GTFC_OFF_IRQ_STAT) begin
            next_rd_data[`GTFC_WRAP_BIT] = timer_wrap_flag;
        end else if (addr_i == `GTFC_OFF_IRQ_MASK) begin
            next_rd_data[`GTFC_WRAP_BIT] = timer_wrap_irq_enable;
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= DATA_ZERO;
        end else if (rd_en_i) begin
            rd_data_o <= next_rd_data;
        end else begin
            rd_data_o <= DATA_ZERO;
        end
    end

endmodule

`default_nettype wire

//--- tb/gtfc_checker.sv
// Concurrent checks on the register port and interrupt line of the timer block.
// Assumes binding to gtfc_timer_top; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "gtfc_map.vh"
module gtfc_checker #(
    parameter integer TICK_CYCLES = 8
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [31:0] rd_data_o,
    input wire logic        irq_o
);
    logic run_seen;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Run enable as last written; the count itself is not visible here
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            run_seen <= 1'b0;
        end else if (wr_en_i && addr_i == `GTFC_OFF_CFG) begin
            run_seen <= wr_data_i[`GTFC_CFG_EN_BIT];
        end
    end
    // ****************************************************************
    // Sequences and properties
    // ****************************************************************
    // A start from the stopped state, so no tick of an old period races the load
    sequence s_wr_start;
        wr_en_i && addr_i == `GTFC_OFF_CFG && !run_seen && wr_data_i[`GTFC_CFG_EN_BIT];
    endsequence
    sequence s_wr_stop;
        wr_en_i && addr_i == `GTFC_OFF_CFG && run_seen && !wr_data_i[`GTFC_CFG_EN_BIT];
    endsequence
    sequence s_rd(logic [11:0] a);
        rd_en_i && addr_i == a;
    endsequence
    sequence s_rd_idle_cnt;
        rd_en_i && addr_i == `GTFC_OFF_CNT && !run_seen;
    endsequence
    // The first 25 MHz period after reset is five cycles long, so skip that edge
    sequence s_rd_free_run;
        rd_en_i && addr_i == `GTFC_OFF_FREE && $past(rst_n_i);
    endsequence
    // Earlier values come back through $past, each step sits a fixed distance away
    property p_free;
        s_rd_free_run ##4 s_rd(`GTFC_OFF_FREE)
            |=> rd_data_o == $past(rd_data_o, 4) + 32'h1;
    endproperty
    property p_back;
        s_wr_start ##1 !wr_en_i [*3] ##1 s_rd(`GTFC_OFF_CFG)
            |=> rd_data_o == ($past(wr_data_i, 5) & 32'h2000_ffff);
    endproperty
    property p_load;
        s_wr_start ##1 !wr_en_i ##1 s_rd(`GTFC_OFF_CNT)
            |=> rd_data_o == ($past(wr_data_i, 3) & 32'h0000_ffff);
    endproperty
    property p_hold;
        s_rd_idle_cnt ##1 !wr_en_i ##1 s_rd(`GTFC_OFF_CNT)
            |=> rd_data_o == $past(rd_data_o, 2);
    endproperty
    AST_FREE_STEP: assert property (p_free) else $error("free count step wrong");
    AST_CFG_BACK: assert property (p_back) else $error("config readback wrong");
    AST_CNT_LOAD: assert property (p_load) else $error("count not loaded");
    AST_CNT_HOLD: assert property (p_hold) else $error("count moved while stopped");
    AST_STOP_FILL: assert property (
        s_wr_stop ##1 !wr_en_i ##1 s_rd(`GTFC_OFF_CFG)
        |=> rd_data_o == 32'h0000_ffff) else $error("preload not filled on stop");
    AST_CNT_RSV: assert property (s_rd(`GTFC_OFF_CNT) |=> rd_data_o[31:16] == 16'h0)
        else $error("count upper bits set");
    AST_UNMAPPED: assert property (rd_en_i && !(addr_i inside {`GTFC_OFF_CFG,
        `GTFC_OFF_CNT, `GTFC_OFF_FREE, `GTFC_OFF_IRQ_STAT, `GTFC_OFF_IRQ_MASK})
        |=> rd_data_o == 32'h0) else $error("unmapped read not zero");
    AST_IRQ_MASKED: assert property (
        wr_en_i && addr_i == `GTFC_OFF_IRQ_MASK && !wr_data_i[0] ##1 !wr_en_i |=> !irq_o)
        else $error("masked interrupt raised");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the general timer and free counter block.
// Assumes TICK_CYCLES of 8 and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "gtfc_map.vh"
module tb_top;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e;} gtfc_row_t;
    localparam logic [11:0] a_cfg = `GTFC_OFF_CFG;
    localparam logic [11:0] a_cnt = `GTFC_OFF_CNT;
    localparam logic [11:0] a_stat = `GTFC_OFF_IRQ_STAT;
    localparam logic [11:0] a_mask = `GTFC_OFF_IRQ_MASK;
    localparam logic [11:0] a_none = 12'h0fc;
    logic        sys_clk;
    logic        rst_n;
    logic [11:0] addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    wire  [31:0] rd_data;
    wire         irq;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    gtfc_row_t   rows [15];
    gtfc_timer_top #(.TICK_CYCLES(8)) gtfc_timer_top_inst (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wr_data),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .irq_o(irq));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // The whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task rs(input logic [11:0] a);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        // Read data stand from this edge; look once they have settled
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        rs(a);
        chk(rd_data, e);
    endtask
    task conclude();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        addr = 12'h000;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        rows = '{'{0, a_cfg, 0, 32'hffff}, '{0, a_cnt, 0, 32'hffff}, '{0, a_stat, 0, 0},
            '{0, a_mask, 0, 0}, '{0, a_none, 0, 0}, '{1, a_cnt, 32'h1234, 0},
            '{0, a_cnt, 0, 32'hffff}, '{1, a_cfg, 32'hffff_0005, 0}, '{0, a_cnt, 0, 5},
            '{0, a_cfg, 0, 32'h2000_0005}, '{1, a_cfg, 7, 0}, '{0, a_cfg, 0, 32'hffff},
            '{0, a_cnt, 0, 32'hffff}, '{1, a_none, 32'hffff_ffff, 0}, '{0, a_cfg, 0, 32'hffff}};
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`GTFC_OFF_FREE, 0);
        for (int i = 0; i < 15; i++) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].e);
        end
        // First tick lands nine cycles after the enabling write
        wr(a_mask, 1);
        wr(a_cfg, 32'h2000_0003);
        cyc(11);
        rd(a_cnt, 2);
        cyc(6);
        rd(a_cnt, 1);
        cyc(16);
        chk({31'h0, irq}, 1);
        rd(a_cnt, 32'hffff);
        wr(a_mask, 0);
        cyc(2);
        chk({31'h0, irq}, 0);
        wr(a_mask, 1);
        cyc(2);
        chk({31'h0, irq}, 1);
        rd(a_stat, 1);
        rd(a_stat, 1);
        // Stop first so no wrap can race the clearing write
        wr(a_cfg, 0);
        wr(a_stat, 1);
        cyc(2);
        chk({31'h0, irq}, 0);
        rd(a_stat, 0);
        cyc(30);
        rd(a_cnt, 32'hffff);
        rd(a_cnt, 32'hffff);
        wr(a_cfg, 32'h2000_0010);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`GTFC_OFF_FREE, 0);
        cyc(2);
        rd(`GTFC_OFF_FREE, 1);
        rd(a_cnt, 32'hffff);
        rd(a_cfg, 32'hffff);
        rd(a_mask, 0);
        conclude();
    end
endmodule
bind gtfc_timer_top gtfc_checker #(.TICK_CYCLES(TICK_CYCLES)) gtfc_checker_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .irq_o(irq_o));
`default_nettype wire
